/* File: design/token_host_pkg.sv */
package token_host_pkg;
  // token space geometry
  localparam int unsigned TOKEN_COUNT     = 8;
  localparam int unsigned INDEX_WIDTH     = 3;
  localparam int unsigned DATA_WIDTH      = 8;
  localparam int unsigned ADDR_WIDTH      = 15;
  // pin timing at 125 MHz core clock
  localparam int unsigned CLK_PERIOD_NS   = 8;
  localparam int unsigned ACCESS_TIME_NS  = 55;
  localparam int unsigned ACCESS_CYCLES   = (ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVER_TIME_NS = 20;
  localparam int unsigned RECOVER_CYCLES  = (RECOVER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_WIDTH       = 8;
  // command codes
  localparam logic [1:0] CMD_ACQUIRE = 2'h0;
  localparam logic [1:0] CMD_RELEASE = 2'h1;
  localparam logic [1:0] CMD_READ    = 2'h2;
  localparam logic [1:0] CMD_INIT    = 2'h3;
  // flag values as written on bit zero
  localparam logic       FLAG_TAKE   = 1'h0;
  localparam logic       FLAG_FREE   = 1'h1;
endpackage

/* File: design/token_pins_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface token_pins_if;
  logic                                     start;
  logic                                     is_write;
  logic [token_host_pkg::INDEX_WIDTH-1:0]   index;
  logic                                     wbit;
  logic                                     done;
  logic [token_host_pkg::DATA_WIDTH-1:0]    rdata;
  modport ctrl (output start, output is_write, output index, output wbit, input done, input rdata);
  modport cycle (input start, input is_write, input index, input wbit, output done, output rdata);
endinterface
`default_nettype wire

/* File: design/token_pin_cycle.sv */
`timescale 1ns/10ps
`default_nettype none
// one token-space access on the device pins, read or write
module token_pin_cycle
(
  // clock and reset
  input  wire logic                                   i_core_clk,
  input  wire logic                                   i_resetn,
  // request side
  token_pins_if.cycle                                 req,
  // device pins
  input  wire logic [token_host_pkg::DATA_WIDTH-1:0]  i_data_in,
  output var  logic [token_host_pkg::DATA_WIDTH-1:0]  o_data_out,
  output var  logic                                   o_data_oe_n,
  output var  logic [token_host_pkg::ADDR_WIDTH-1:0]  o_addr,
  output var  logic                                   o_array_select_n,
  output var  logic                                   o_token_space_select_n,
  output var  logic                                   o_read_enable_n,
  output var  logic                                   o_write_n
);
  typedef enum logic [2:0]
  {
    ST_IDLE    = 3'h1,
    ST_ACTIVE  = 3'h2,
    ST_RECOVER = 3'h4
  } cyc_state_t;

  typedef struct packed
  {
    cyc_state_t                              state;
    logic [token_host_pkg::CNT_WIDTH-1:0]    cnt;
    logic                                    is_write;
    logic [token_host_pkg::DATA_WIDTH-1:0]   s1;
    logic [token_host_pkg::DATA_WIDTH-1:0]   s2;
    logic [token_host_pkg::DATA_WIDTH-1:0]   s3;
    logic [token_host_pkg::DATA_WIDTH-1:0]   rdata;
    logic                                    done;
    logic [token_host_pkg::DATA_WIDTH-1:0]   data_out;
    logic                                    data_oe_n;
    logic [token_host_pkg::ADDR_WIDTH-1:0]   addr;
    logic                                    sem_n;
    logic                                    oe_n;
    logic                                    we_n;
  } cyc_regs_t;

  cyc_regs_t r;
  cyc_regs_t next_r;

  always_comb
  begin
    next_r      = r;
    next_r.done = 1'b0;
    // three-stage capture of the data pins
    next_r.s1   = i_data_in;
    next_r.s2   = r.s1;
    next_r.s3   = r.s2;
    case (r.state)
      ST_IDLE:
      begin
        if (req.start)
        begin
          next_r.state    = ST_ACTIVE;
          next_r.cnt      = token_host_pkg::CNT_WIDTH'(token_host_pkg::ACCESS_CYCLES);
          next_r.is_write = req.is_write;
          next_r.addr     = {{(token_host_pkg::ADDR_WIDTH-token_host_pkg::INDEX_WIDTH){1'b0}}, req.index};
          next_r.sem_n    = 1'b0;
          next_r.oe_n     = req.is_write;
          next_r.we_n     = ~req.is_write;
          next_r.data_out = {{(token_host_pkg::DATA_WIDTH-1){1'b0}}, req.wbit};
          next_r.data_oe_n = ~req.is_write;
        end
      end
      ST_ACTIVE:
      begin
        if (r.cnt == '0)
        begin
          if (!r.is_write && (r.s2 == r.s3))
            next_r.rdata = r.s3;
          // drop select and enable between accesses
          next_r.sem_n     = 1'b1;
          next_r.oe_n      = 1'b1;
          next_r.we_n      = 1'b1;
          next_r.data_oe_n = 1'b1;
          next_r.state     = ST_RECOVER;
          next_r.cnt       = token_host_pkg::CNT_WIDTH'(token_host_pkg::RECOVER_CYCLES);
        end
        else
          next_r.cnt = r.cnt - 1'b1;
      end
      ST_RECOVER:
      begin
        if (r.cnt == '0)
        begin
          next_r.done  = 1'b1;
          next_r.state = ST_IDLE;
        end
        else
          next_r.cnt = r.cnt - 1'b1;
      end
      default:
        next_r.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      r           <= '0;
      r.state     <= ST_IDLE;
      r.data_oe_n <= 1'b1;
      r.sem_n     <= 1'b1;
      r.oe_n      <= 1'b1;
      r.we_n      <= 1'b1;
    end
    else
      r <= next_r;
  end

  assign req.done               = r.done;
  assign req.rdata              = r.rdata;
  assign o_data_out             = r.data_out;
  assign o_data_oe_n            = r.data_oe_n;
  assign o_addr                 = r.addr;
  assign o_array_select_n       = 1'b1;
  assign o_token_space_select_n = r.sem_n;
  assign o_read_enable_n        = r.oe_n;
  assign o_write_n              = r.we_n;
endmodule
`default_nettype wire

/* File: design/token_host.sv */
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - write zero requests, write one releases
// - token select low, ordinary memory access
// - drop select between polling reads
// - acquire writes zero then reads back
// - failed acquire polls or withdraws request
// - software frees every token at start
// - array enable high during token access
module token_host
#(
  parameter int unsigned POLL_LIMIT = 16
)
(
  // clock and reset
  input  wire logic                                     i_core_clk,
  input  wire logic                                     i_resetn,
  // command port
  input  wire logic                                     i_cmd_valid,
  input  wire logic [1:0]                               i_cmd_op,
  input  wire logic [token_host_pkg::INDEX_WIDTH-1:0]   i_cmd_index,
  output logic                                          o_cmd_ready,
  output logic                                          o_resp_valid,
  output logic                                          o_resp_owned,
  output logic                                          o_resp_error,
  output logic [token_host_pkg::TOKEN_COUNT-1:0]        o_owned,
  // device pins
  input  wire logic [token_host_pkg::DATA_WIDTH-1:0]    i_data_in,
  output logic [token_host_pkg::DATA_WIDTH-1:0]         o_data_out,
  output logic                                          o_data_oe_n,
  output logic [token_host_pkg::ADDR_WIDTH-1:0]         o_addr,
  output logic                                          o_array_select_n,
  output logic                                          o_token_space_select_n,
  output logic                                          o_read_enable_n,
  output logic                                          o_write_n
);
  // ****************************************************
  // states and registers
  // ****************************************************
  typedef enum logic [5:0]
  {
    ST_INIT    = 6'h01,
    ST_IDLE    = 6'h02,
    ST_WRITE   = 6'h04,
    ST_VERIFY  = 6'h08,
    ST_WAIT    = 6'h10,
    ST_RESP    = 6'h20
  } host_state_t;

  typedef struct packed
  {
    host_state_t                               state;
    logic [1:0]                                op;
    logic [token_host_pkg::INDEX_WIDTH-1:0]    index;
    logic [token_host_pkg::CNT_WIDTH-1:0]      polls;
    logic                                      start;
    logic                                      is_write;
    logic                                      wbit;
    logic                                      ready;
    logic                                      resp_valid;
    logic                                      resp_owned;
    logic                                      resp_error;
    logic [token_host_pkg::TOKEN_COUNT-1:0]    owned;
  } host_regs_t;

  host_regs_t r;
  host_regs_t next_r;
  token_pins_if pins ();

  // ****************************************************
  // pin cycle engine
  // ****************************************************
  token_pin_cycle u_cycle
  (
    .i_core_clk             (i_core_clk),
    .i_resetn               (i_resetn),
    .req                    (pins.cycle),
    .i_data_in              (i_data_in),
    .o_data_out             (o_data_out),
    .o_data_oe_n            (o_data_oe_n),
    .o_addr                 (o_addr),
    .o_array_select_n       (o_array_select_n),
    .o_token_space_select_n (o_token_space_select_n),
    .o_read_enable_n        (o_read_enable_n),
    .o_write_n              (o_write_n)
  );

  assign pins.start    = r.start;
  assign pins.is_write = r.is_write;
  assign pins.index    = r.index;
  assign pins.wbit     = r.wbit;

  // ****************************************************
  // command sequencer
  // ****************************************************
  always_comb
  begin
    next_r            = r;
    next_r.start      = 1'b0;
    next_r.resp_valid = 1'b0;
    case (r.state)
      ST_INIT:
      begin
        if (r.start)
          next_r.start = 1'b0;
        else if (pins.done)
        begin
          if (r.index == token_host_pkg::INDEX_WIDTH'(token_host_pkg::TOKEN_COUNT - 1))
          begin
            next_r.index = '0;
            // a commanded init answers like any other command
            if (r.op == token_host_pkg::CMD_INIT)
            begin
              next_r.resp_owned = 1'b0;
              next_r.resp_error = 1'b0;
              next_r.state      = ST_RESP;
            end
            else
            begin
              next_r.state = ST_IDLE;
              next_r.ready = 1'b1;
            end
          end
          else
          begin
            next_r.index = r.index + 1'b1;
            next_r.start = 1'b1;
          end
        end
      end
      ST_IDLE:
      begin
        if (i_cmd_valid)
        begin
          next_r.ready    = 1'b0;
          next_r.op       = i_cmd_op;
          next_r.index    = i_cmd_index;
          next_r.polls    = '0;
          next_r.start    = 1'b1;
          next_r.is_write = (i_cmd_op != token_host_pkg::CMD_READ);
          next_r.wbit     = (i_cmd_op == token_host_pkg::CMD_ACQUIRE) ? token_host_pkg::FLAG_TAKE
                                                                     : token_host_pkg::FLAG_FREE;
          if (i_cmd_op == token_host_pkg::CMD_INIT)
          begin
            next_r.index = '0;
            next_r.owned = '0;
            next_r.state = ST_INIT;
          end
          else if (i_cmd_op == token_host_pkg::CMD_ACQUIRE)
            next_r.state = ST_WRITE;
          else
            next_r.state = ST_WAIT;
        end
      end
      ST_WRITE:
      begin
        if (pins.done)
        begin
          next_r.start    = 1'b1;
          next_r.is_write = 1'b0;
          next_r.state    = ST_VERIFY;
        end
      end
      ST_VERIFY:
      begin
        if (pins.done)
        begin
          // low bit zero means we own it
          if (pins.rdata[0] == token_host_pkg::FLAG_TAKE)
          begin
            next_r.owned[r.index] = 1'b1;
            next_r.resp_owned     = 1'b1;
            next_r.resp_error     = 1'b0;
            next_r.state          = ST_RESP;
          end
          else if (r.polls == token_host_pkg::CNT_WIDTH'(POLL_LIMIT - 1))
          begin
            // give up by withdrawing the request
            next_r.start      = 1'b1;
            next_r.is_write   = 1'b1;
            next_r.wbit       = token_host_pkg::FLAG_FREE;
            next_r.resp_owned = 1'b0;
            next_r.resp_error = 1'b1;
            next_r.state      = ST_WAIT;
          end
          else
          begin
            // each poll is a fresh select cycle
            next_r.polls = r.polls + 1'b1;
            next_r.start = 1'b1;
          end
        end
      end
      ST_WAIT:
      begin
        if (pins.done)
        begin
          if (r.op == token_host_pkg::CMD_RELEASE)
          begin
            next_r.owned[r.index] = 1'b0;
            next_r.resp_owned     = 1'b0;
            next_r.resp_error     = 1'b0;
          end
          else if (r.op == token_host_pkg::CMD_READ)
          begin
            next_r.resp_owned = (pins.rdata == '0);
            next_r.resp_error = (pins.rdata != '0) && (pins.rdata != '1);
          end
          next_r.state = ST_RESP;
        end
      end
      ST_RESP:
      begin
        next_r.resp_valid = 1'b1;
        next_r.ready      = 1'b1;
        next_r.state      = ST_IDLE;
      end
      default:
        next_r.state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_resetn)
    begin
      r          <= '0;
      r.state    <= ST_INIT;
      r.start    <= 1'b1;
      r.is_write <= 1'b1;
      r.wbit     <= token_host_pkg::FLAG_FREE;
    end
    else
      r <= next_r;
  end

  assign o_cmd_ready  = r.ready;
  assign o_resp_valid = r.resp_valid;
  assign o_resp_owned = r.resp_owned;
  assign o_resp_error = r.resp_error;
  assign o_owned      = r.owned;
endmodule
`default_nettype wire

/* File: verification/token_dev_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// two-port token flag device
// ********
module token_dev_model
(
  // sampling clock
  input  wire logic       i_core_clk,
  // host port, only the low index lines reach here
  input  wire logic [2:0] i_ix,
  input  wire logic       i_sel_n,
  input  wire logic       i_oe_n,
  input  wire logic       i_we_n,
  input  wire logic [7:0] i_d,
  output var  logic [7:0] o_q,
  // opposite port
  input  wire logic [2:0] i_r_ix,
  input  wire logic       i_r_sel_n,
  input  wire logic       i_r_oe_n,
  input  wire logic       i_r_we_n,
  input  wire logic       i_r_d,
  output var  logic [7:0] o_r_q
);
  logic [7:0] req_l = 8'h5a;
  logic [7:0] req_r = 8'hff;
  logic [7:0] own_l = 8'ha5;
  logic [7:0] own_r = 8'h00;
  logic       act_l = 1'h0;
  logic       act_r = 1'h0;
  initial o_q = 8'h3c;
  initial o_r_q = 8'h3c;
  always @(posedge i_core_clk)
  begin
    if (!i_sel_n && !i_we_n)
      req_l[i_ix] = i_d[0];
    if (!i_r_sel_n && !i_r_we_n)
      req_r[i_r_ix] = i_r_d;
    own_l = own_l & ~req_l;
    own_r = own_r & ~req_r;
    own_l = own_l | (~own_r & ~req_l);
    own_r = own_r | (~own_l & ~req_r);
    // flag on all bits, held while read stays active
    if (!i_sel_n && !i_oe_n)
    begin
      if (!act_l)
        o_q <= {8{~own_l[i_ix]}};
      act_l = 1'h1;
    end
    else
    begin
      // select or read enable high leaves the port idle
      act_l = 1'h0;
      o_q <= ~o_q;
    end
    if (!i_r_sel_n && !i_r_oe_n)
    begin
      if (!act_r)
        o_r_q <= {8{~own_r[i_r_ix]}};
      act_r = 1'h1;
    end
    else
    begin
      act_r = 1'h0;
      o_r_q <= ~o_r_q;
    end
  end
endmodule
`default_nettype wire

/* File: verification/token_host_assertions.sv */
`timescale 1ns/10ps
`default_nettype none
// ********
// pin protocol checks
// ********
module token_host_assertions
#(
  parameter int unsigned POLL_LIMIT = 16
)
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  // command port
  input  wire logic        i_cmd_valid,
  input  wire logic [1:0]  i_cmd_op,
  input  wire logic [2:0]  i_cmd_index,
  input  wire logic        o_cmd_ready,
  // device pins
  input  wire logic [7:0]  o_data_out,
  input  wire logic        o_data_oe_n,
  input  wire logic [14:0] o_addr,
  input  wire logic        o_array_select_n,
  input  wire logic        o_token_space_select_n,
  input  wire logic        o_read_enable_n,
  input  wire logic        o_write_n
);
  logic [2:0] cix;
  logic [3:0] frees;
  always_ff @(posedge i_core_clk)
  begin
    if (i_cmd_valid && o_cmd_ready)
      cix <= i_cmd_index;
    if (!i_resetn || (i_cmd_valid && o_cmd_ready && i_cmd_op == token_host_pkg::CMD_INIT))
      frees <= 4'h0;
    else if ($fell(o_write_n) && o_data_out[0] && frees != 4'h8)
      frees <= frees + 4'h1;
  end
  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  sequence take(logic [1:0] op);
    i_cmd_valid && o_cmd_ready && i_cmd_op == op;
  endsequence
  sequence wr(logic b);
    !o_write_n && !o_token_space_select_n && !o_data_oe_n && o_data_out == {7'h0, b} && o_addr == {12'h0, cix};
  endsequence
  sequence rd;
    !o_read_enable_n && o_write_n && o_data_oe_n && !o_token_space_select_n && o_addr == {12'h0, cix};
  endsequence
  acquire_write_a: assert property (take(token_host_pkg::CMD_ACQUIRE) |-> ##[1:2] wr(1'h0))
    else $error("acquire does not open with a zero write");
  release_write_a: assert property (take(token_host_pkg::CMD_RELEASE) |-> ##[1:2] wr(1'h1))
    else $error("release does not write a one");
  read_only_a: assert property (take(token_host_pkg::CMD_READ) |-> ##[1:2] rd)
    else $error("read command without a clean read cycle");
  array_off_a: assert property (o_array_select_n)
    else $error("array enable driven active");
  strobe_select_a: assert property (!o_write_n || !o_read_enable_n |-> !o_token_space_select_n && (o_write_n || o_read_enable_n))
    else $error("strobe outside token select");
  write_data_a: assert property (!o_write_n |-> !o_data_oe_n && o_data_out[7:1] == 7'h0)
    else $error("write data not on bit zero alone");
  active_len_a: assert property ($fell(o_token_space_select_n) |-> !o_token_space_select_n[*8] ##1 o_token_space_select_n)
    else $error("token select active phase wrong length");
  recover_gap_a: assert property ($rose(o_token_space_select_n) |-> o_token_space_select_n[*4])
    else $error("token select gap too short");
  init_first_a: assert property ($rose(o_cmd_ready) |-> frees == 4'h8)
    else $error("ready before every token was freed");
endmodule
bind token_host token_host_assertions #(.POLL_LIMIT(POLL_LIMIT)) i_chk (.i_core_clk, .i_resetn, .i_cmd_valid,
  .i_cmd_op, .i_cmd_index, .o_cmd_ready, .o_data_out, .o_data_oe_n, .o_addr, .o_array_select_n,
  .o_token_space_select_n, .o_read_enable_n, .o_write_n);
`default_nettype wire

/* File: verification/token_host_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module token_host_tb;
  // ********
  // bench signals
  // ********
  logic            i_core_clk = 1'h0;
  logic            i_resetn = 1'h0;
  logic            i_cmd_valid = 1'h0;
  logic [1:0]      i_cmd_op = 2'h2;
  logic [2:0]      i_cmd_index = 3'h0;
  logic            o_cmd_ready, o_resp_valid, o_resp_owned, o_resp_error, o_data_oe_n;
  logic            o_array_select_n, o_token_space_select_n, o_read_enable_n, o_write_n;
  logic [7:0]      o_owned, o_data_out, dev_q, r_q, q, held;
  logic [14:0]     o_addr;
  wire logic [7:0] i_data_in;
  logic            r_sel_n = 1'h1, r_oe_n = 1'h1, r_we_n = 1'h1, r_d = 1'h1;
  logic [2:0]      r_ix = 3'h0, k, j;
  int              mismatches = 0, compares = 0, cycles = 0, i;
  always #4 i_core_clk = ~i_core_clk;
  // host drives the data lines only while its enable is low
  assign i_data_in = o_data_oe_n ? dev_q : o_data_out;
  token_host #(.POLL_LIMIT(2)) i_dut (.i_core_clk, .i_resetn, .i_cmd_valid, .i_cmd_op, .i_cmd_index,
    .o_cmd_ready, .o_resp_valid, .o_resp_owned, .o_resp_error, .o_owned, .i_data_in, .o_data_out, .o_data_oe_n,
    .o_addr, .o_array_select_n, .o_token_space_select_n, .o_read_enable_n, .o_write_n);
  token_dev_model i_dev (.i_core_clk, .i_ix(o_addr[2:0]), .i_sel_n(o_token_space_select_n),
    .i_oe_n(o_read_enable_n), .i_we_n(o_write_n), .i_d(i_data_in), .o_q(dev_q), .i_r_ix(r_ix),
    .i_r_sel_n(r_sel_n), .i_r_oe_n(r_oe_n), .i_r_we_n(r_we_n), .i_r_d(r_d), .o_r_q(r_q));
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // all bits copy the flag, low when held
  function automatic logic [7:0] flag(input logic mine);
    return {8{~mine}};
  endfunction
  task results;
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task cmd(input logic [1:0] op, input logic [2:0] ix);
    int n;
    for (n = 0; n < 999 && o_cmd_ready !== 1'h1; n++)
      @(posedge i_core_clk);
    i_cmd_valid <= 1'h1;
    i_cmd_op <= op;
    i_cmd_index <= ix;
    @(posedge i_core_clk);
    i_cmd_valid <= 1'h0;
    for (n = 0; n < 999 && o_resp_valid !== 1'h1; n++)
      @(posedge i_core_clk);
    if (n == 999)
      mismatches++;
  endtask
  // one access from the opposite port, read value left in q
  task rp(input logic w, input logic [2:0] ix, input logic d);
    @(posedge i_core_clk);
    r_sel_n <= 1'h0;
    r_we_n <= ~w;
    r_oe_n <= w;
    r_ix <= ix;
    r_d <= d;
    repeat (3) @(posedge i_core_clk);
    q = r_q;
    r_sel_n <= 1'h1;
    r_we_n <= 1'h1;
    r_oe_n <= 1'h1;
  endtask
  always @(posedge i_core_clk)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      mismatches++;
      results();
    end
  end
  // ********
  // scenarios
  // ********
  initial
  begin
    held = 8'h00;
    void'($urandom(32'h9d67));
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'h1;
    for (i = 0; i < 8; i++)
      rp(1'h1, 3'(i), 1'h1);
    cmd(token_host_pkg::CMD_READ, 3'h0);
    check(o_owned, 8'h00);
    check({7'h0, o_resp_owned}, 8'h00);
    k = 3'($urandom);
    for (i = 0; i < 8; i++)
    begin
      cmd(token_host_pkg::CMD_ACQUIRE, k);
      held[k] = 1'h1;
      check(o_owned, held);
      rp(1'h0, k, 1'h0);
      check(q, flag(1'h0));
      k = k + 3'h1;
    end
    j = 3'($urandom);
    rp(1'h1, j, 1'h0);
    rp(1'h0, j, 1'h0);
    check(q, flag(1'h0));
    cmd(token_host_pkg::CMD_READ, j);
    check({7'h0, o_resp_owned}, 8'h01);
    cmd(token_host_pkg::CMD_RELEASE, j);
    held[j] = 1'h0;
    rp(1'h0, j, 1'h0);
    check(q, flag(1'h1));
    cmd(token_host_pkg::CMD_ACQUIRE, j);
    check({6'h0, o_resp_error, o_resp_owned}, 8'h02);
    check(o_owned, held);
    rp(1'h1, j, 1'h1);
    cmd(token_host_pkg::CMD_READ, j);
    check({7'h0, o_resp_owned}, 8'h00);
    rp(1'h0, j, 1'h0);
    check(q, flag(1'h0));
    cmd(token_host_pkg::CMD_INIT, 3'h0);
    check(o_owned, 8'h00);
    check({6'h0, o_resp_error, o_resp_owned}, 8'h00);
    k = 3'($urandom);
    rp(1'h1, k, 1'h0);
    rp(1'h0, k, 1'h0);
    check(q, flag(1'h1));
    cmd(token_host_pkg::CMD_READ, k);
    check({6'h0, o_resp_error, o_resp_owned}, 8'h00);
    rp(1'h1, k, 1'h1);
    fork
      cmd(token_host_pkg::CMD_ACQUIRE, j);
      rp(1'h1, j, 1'h0);
    join
    rp(1'h0, j, 1'h0);
    check({7'h0, o_resp_owned ^ (q == 8'h00)}, 8'h01);
    results();
  end
endmodule
`default_nettype wire
